// [shared/malt_pkg.sv]
// constants, types and helpers for the mac address lookup table
// ==========================================================
// Notes on behaviour
// [RULE_01] 1024 buckets of four ways, 4096 entries
// [RULE_02] mac plus optional group id hash to bucket
// [RULE_03] free way first, else replace LRU dynamic
// [RULE_04] third or fourth static raises almost-full, address
// [RULE_05] static write into four statics fails
// [RULE_06] four statics block learning, learn-fail raised
// [RULE_07] destination consults all, source only this
// [RULE_08] static result beats dynamic; statics never age
// [RULE_09] host reads anything, writes only static entries
// [RULE_10] hash lookup, direct addressing, sequential search
// [RULE_11] host puts direct index in key bits
// [RULE_12] host supplies group id when vlan on
// [RULE_13] op codes 01 write, 10 read, 11 search
// [RULE_14] go starts op, clears when done, found
// [RULE_15] combined bit is found or not busy
// [RULE_16] entry registers zero when nothing found
// [RULE_17] search starts at top, clears found
// [RULE_18] reading entry four resumes the search
// [RULE_19] go stays until end; clearing aborts
// [RULE_20] host polls found, reads four, repeats
// [RULE_21] count of valid entries readable
// [RULE_22] host does read-modify-write with static set
// [RULE_23] per-bucket LRU ranks updated on every touch
// [RULE_24] hash variants chosen by option plus salt parameter
// [RULE_25] age reloads on touch, decays, dynamic expires
package malt_pkg;
    // ==========================================================
    // geometry and timing
    localparam int NUM_BUCKETS = 1024;
    localparam int NUM_WAYS = 4;
    localparam logic [7:0] LRU_INIT = 8'hE4;
    localparam logic [2:0] AGE_DEFAULT = 3'h7;
    // ==========================================================
    // register offsets
    localparam logic [15:0] OFF_EIDX0 = 16'h0400;
    localparam logic [15:0] OFF_EIDX1 = 16'h0404;
    localparam logic [15:0] OFF_HCFG = 16'h0408;
    localparam logic [15:0] OFF_KEY_HI = 16'h0410;
    localparam logic [15:0] OFF_KEY_LO = 16'h0414;
    localparam logic [15:0] OFF_CTRL = 16'h0418;
    localparam logic [15:0] OFF_ENT1 = 16'h0420;
    localparam logic [15:0] OFF_ENT2 = 16'h0424;
    localparam logic [15:0] OFF_ENT3 = 16'h0428;
    localparam logic [15:0] OFF_ENT4 = 16'h042C;
    // ==========================================================
    // control register fields
    localparam int CTRL_GO = 7;
    localparam int CTRL_FOUND = 6;
    localparam int CTRL_DONE_OR_FOUND = 5;
    localparam int CTRL_DIRECT = 4;
    localparam int CTRL_CNT_LSB = 16;
    localparam int HCFG_VLAN = 2;

    typedef enum logic [1:0] {
        MALT_OP_NONE = 2'h0,
        MALT_OP_WRITE = 2'h1,
        MALT_OP_READ = 2'h2,
        MALT_OP_SEARCH = 2'h3
    } malt_op_t;

    typedef enum logic [2:0] {
        MALT_S_CLR = 3'h0,
        MALT_S_IDLE = 3'h1,
        MALT_S_SRCH = 3'h2,
        MALT_S_SHOLD = 3'h3,
        MALT_S_AGE = 3'h4
    } malt_fsm_t;

    typedef struct packed {
        logic valid;
        logic isStatic;
        logic srcFilt;
        logic dstFilt;
        logic [2:0] age;
        logic [2:0] mstp;
        logic override;
        logic [2:0] fwd;
        logic [6:0] filter_group_id;
        logic [47:0] mac;
    } malt_entry_t;

    typedef struct packed {
        logic req;
        logic learn;
        logic [47:0] mac;
        logic [6:0] filter_group_id;
        logic [2:0] port;
        logic stHit;
        logic [2:0] stFwd;
    } malt_core_req_t;

    typedef struct packed {
        logic ack;
        logic hit;
        logic isStatic;
        logic [2:0] fwd;
        logic drop;
    } malt_core_rsp_t;

    typedef struct packed {
        logic almostFull;
        logic writeFail;
        logic learnFail;
    } malt_events_t;

    typedef struct packed {
        malt_fsm_t fsm;
        logic [12:0] scan;
        logic go;
        logic found;
        logic direct;
        malt_op_t op;
        logic [1:0] hashOpt;
        logic vlanEn;
        logic [22:0] keyHi;
        logic [31:0] keyLo;
        malt_entry_t ent;
        logic [11:0] eidx0;
        logic [9:0] eidx1;
        logic [12:0] validCnt;
        logic agePend;
        logic [31:0] rdata;
        malt_core_rsp_t rsp;
        malt_events_t evt;
    } malt_state_t;

    // ==========================================================
    // helpers
    function automatic logic [9:0] maltHash(input logic [47:0] mac, input logic [6:0] filter_group_id,
                                            input logic useFid, input logic [1:0] opt,
                                            input logic [9:0] salt);
        logic [9:0] fold;
        logic [9:0] grp;
        fold = mac[9:0] ^ mac[19:10] ^ mac[29:20] ^ mac[39:30] ^ {2'h0, mac[47:40]};
        grp = useFid ? {3'h0, filter_group_id} : 10'h000;
        case (opt)
            2'h0: maltHash = fold ^ grp ^ salt;
            2'h1: maltHash = {fold[4:0], fold[9:5]} ^ grp ^ salt;
            2'h2: maltHash = mac[9:0] ^ grp ^ salt;
            default: maltHash = ~fold ^ grp ^ salt;
        endcase
    endfunction : maltHash

    function automatic logic [7:0] maltLruTouch(input logic [7:0] lru, input logic [1:0] way);
        logic [1:0] rank;
        rank = lru[2 * way +: 2];
        maltLruTouch = lru;
        for (int w = 0; w < NUM_WAYS; w++) begin
            if (lru[2 * w +: 2] < rank) begin
                maltLruTouch[2 * w +: 2] = lru[2 * w +: 2] + 2'h1;
            end
        end
        maltLruTouch[2 * way +: 2] = 2'h0;
    endfunction : maltLruTouch

    function automatic logic [1:0] maltLruVictim(input logic [7:0] lru, input logic [3:0] pinned);
        logic [2:0] best;
        maltLruVictim = 2'h0;
        best = 3'h0;
        for (int w = 0; w < NUM_WAYS; w++) begin
            if (!pinned[w] && {1'b1, lru[2 * w +: 2]} > best) begin
                maltLruVictim = 2'(w);
                best = {1'b1, lru[2 * w +: 2]};
            end
        end
    endfunction : maltLruVictim
endpackage : malt_pkg

// [rtl/malt_table.sv]
// mac address lookup table: storage, host indirect access, lookup, learning and aging
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module malt_table #(
    parameter logic [9:0] HASH_SALT = 10'h000,
    parameter logic [2:0] AGE_INIT = malt_pkg::AGE_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // switch core lookup, learning and aging
    input malt_pkg::malt_core_req_t coreReq,
    input wire logic ageTick,
    output malt_pkg::malt_core_rsp_t coreRsp,
    // events toward the global interrupt logic
    output malt_pkg::malt_events_t events
);
    if (AGE_INIT == 3'h0) begin : g_age_check
        $error("age reload value must be nonzero");
    end

    // ==========================================================
    // storage
    malt_pkg::malt_entry_t mem [malt_pkg::NUM_BUCKETS * malt_pkg::NUM_WAYS]; // RULE_01
    logic [7:0] lru [malt_pkg::NUM_BUCKETS];
    malt_pkg::malt_state_t state_ff;
    malt_pkg::malt_state_t nxt_state;
    logic memWe;
    logic [11:0] memAddr;
    malt_pkg::malt_entry_t memData;
    malt_pkg::malt_entry_t memOld;
    logic lruWe;
    logic [9:0] lruAddr;
    logic [7:0] lruNew;
    logic [7:0] lruCur;

    // ==========================================================
    // bucket view for the current key
    logic [47:0] keyMac;
    logic [6:0] keyFid;
    logic [9:0] bucket;
    malt_pkg::malt_entry_t ways [malt_pkg::NUM_WAYS];
    logic anyHit;
    logic anyFree;
    logic [1:0] hitWay;
    logic [1:0] freeWay;
    logic [1:0] tgtWay;
    logic [3:0] pinned;
    logic [2:0] nStat;
    logic bucketFull;
    malt_pkg::malt_entry_t hitEnt;

    always_comb begin
        keyMac = state_ff.go ? {state_ff.keyHi[15:0], state_ff.keyLo} : coreReq.mac;
        keyFid = state_ff.go ? state_ff.keyHi[22:16] : coreReq.filter_group_id;
        bucket = malt_pkg::maltHash(keyMac, keyFid, state_ff.vlanEn, state_ff.hashOpt, HASH_SALT); // RULE_02 RULE_24
        if (state_ff.go && state_ff.direct) begin
            bucket = state_ff.keyLo[11:2];
        end
        anyHit = 1'b0;
        anyFree = 1'b0;
        hitWay = 2'h0;
        freeWay = 2'h0;
        pinned = 4'h0;
        nStat = 3'h0;
        for (int w = malt_pkg::NUM_WAYS - 1; w >= 0; w--) begin
            ways[w] = mem[{bucket, 2'(w)}];
            pinned[w] = ways[w].valid && ways[w].isStatic;
            nStat = nStat + 3'(pinned[w]);
            if (!ways[w].valid) begin
                anyFree = 1'b1;
                freeWay = 2'(w);
            end else if (ways[w].mac == keyMac && (!state_ff.vlanEn || ways[w].filter_group_id == keyFid)) begin
                anyHit = 1'b1;
                hitWay = 2'(w);
            end
        end
        hitEnt = ways[hitWay];
        bucketFull = nStat == 3'h4;
        lruCur = lru[lruAddr];
        // matching way first, then a free way, then the least recently used dynamic way
        tgtWay = anyHit ? hitWay : (anyFree ? freeWay : malt_pkg::maltLruVictim(lruCur, pinned)); // RULE_03
        memOld = mem[memAddr];
    end

    // ==========================================================
    // next state
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rdata = 32'h0000_0000;
        nxt_state.rsp = '0;
        nxt_state.evt = '0;
        memWe = 1'b0;
        memAddr = state_ff.scan[11:0];
        memData = '0;
        lruWe = 1'b0;
        lruAddr = bucket;
        lruNew = 8'h00;

        // register reads
        if (regRd) begin
            case (regAddr)
                malt_pkg::OFF_EIDX0: nxt_state.rdata = {20'h0_0000, state_ff.eidx0};
                malt_pkg::OFF_EIDX1: nxt_state.rdata = {22'h00_0000, state_ff.eidx1};
                malt_pkg::OFF_HCFG: nxt_state.rdata = {29'h0000_0000, state_ff.vlanEn, state_ff.hashOpt};
                malt_pkg::OFF_KEY_HI: nxt_state.rdata = {9'h000, state_ff.keyHi};
                malt_pkg::OFF_KEY_LO: nxt_state.rdata = state_ff.keyLo;
                malt_pkg::OFF_CTRL: begin
                    nxt_state.rdata[malt_pkg::CTRL_CNT_LSB +: 13] = state_ff.validCnt; // RULE_21
                    nxt_state.rdata[malt_pkg::CTRL_GO] = state_ff.go;
                    nxt_state.rdata[malt_pkg::CTRL_FOUND] = state_ff.found;
                    nxt_state.rdata[malt_pkg::CTRL_DONE_OR_FOUND] = state_ff.found || !state_ff.go; // RULE_15
                    nxt_state.rdata[malt_pkg::CTRL_DIRECT] = state_ff.direct;
                    nxt_state.rdata[1:0] = state_ff.op;
                end
                malt_pkg::OFF_ENT1: nxt_state.rdata = {state_ff.ent.isStatic, state_ff.ent.srcFilt,
                    state_ff.ent.dstFilt, state_ff.ent.age, 23'h00_0000, state_ff.ent.mstp};
                malt_pkg::OFF_ENT2: nxt_state.rdata = {state_ff.ent.override, 28'h000_0000, state_ff.ent.fwd};
                malt_pkg::OFF_ENT3: nxt_state.rdata = {9'h000, state_ff.ent.filter_group_id, state_ff.ent.mac[47:32]};
                malt_pkg::OFF_ENT4: nxt_state.rdata = state_ff.ent.mac[31:0];
                default: nxt_state.rdata = 32'h0000_0000;
            endcase
            if (regAddr == malt_pkg::OFF_ENT4 && state_ff.fsm == malt_pkg::MALT_S_SHOLD) begin
                nxt_state.fsm = malt_pkg::MALT_S_SRCH; // RULE_18
                nxt_state.found = 1'b0;
            end
        end

        // register writes
        if (regWr) begin
            case (regAddr)
                malt_pkg::OFF_HCFG: begin
                    nxt_state.hashOpt = regWdata[1:0];
                    nxt_state.vlanEn = regWdata[malt_pkg::HCFG_VLAN];
                end
                malt_pkg::OFF_KEY_HI: nxt_state.keyHi = regWdata[22:0];
                malt_pkg::OFF_KEY_LO: nxt_state.keyLo = regWdata;
                malt_pkg::OFF_CTRL: begin
                    if (!state_ff.go) begin
                        nxt_state.go = regWdata[malt_pkg::CTRL_GO]; // RULE_14
                        nxt_state.op = malt_pkg::malt_op_t'(regWdata[1:0]); // RULE_13
                        nxt_state.direct = regWdata[malt_pkg::CTRL_DIRECT];
                        if (regWdata[malt_pkg::CTRL_GO]) begin
                            nxt_state.found = 1'b0;
                        end
                    end else if (!regWdata[malt_pkg::CTRL_GO]) begin
                        nxt_state.go = 1'b0; // RULE_19
                    end
                end
                malt_pkg::OFF_ENT1: begin
                    nxt_state.ent.isStatic = regWdata[31];
                    nxt_state.ent.srcFilt = regWdata[30];
                    nxt_state.ent.dstFilt = regWdata[29];
                    nxt_state.ent.age = regWdata[28:26];
                    nxt_state.ent.mstp = regWdata[2:0];
                end
                malt_pkg::OFF_ENT2: begin
                    nxt_state.ent.override = regWdata[31];
                    nxt_state.ent.fwd = regWdata[2:0];
                end
                malt_pkg::OFF_ENT3: begin
                    nxt_state.ent.filter_group_id = regWdata[22:16];
                    nxt_state.ent.mac[47:32] = regWdata[15:0];
                end
                malt_pkg::OFF_ENT4: nxt_state.ent.mac[31:0] = regWdata;
                default: ;
            endcase
        end

        // table engine
        case (state_ff.fsm)
            malt_pkg::MALT_S_CLR: begin
                memWe = 1'b1;
                lruAddr = state_ff.scan[11:2];
                lruWe = state_ff.scan[1:0] == 2'h3;
                lruNew = malt_pkg::LRU_INIT;
                nxt_state.scan = state_ff.scan + 13'h0001;
                if (state_ff.scan[11:0] == 12'hFFF) begin
                    nxt_state.fsm = malt_pkg::MALT_S_IDLE;
                    nxt_state.scan = 13'h0000;
                end
            end
            malt_pkg::MALT_S_IDLE: begin
                if (state_ff.go && state_ff.op == malt_pkg::MALT_OP_SEARCH) begin
                    nxt_state.scan = 13'h0000; // RULE_17
                    nxt_state.found = 1'b0;
                    nxt_state.fsm = malt_pkg::MALT_S_SRCH;
                end else if (state_ff.go && state_ff.op == malt_pkg::MALT_OP_READ) begin
                    nxt_state.go = 1'b0;
                    if (state_ff.direct) begin
                        memAddr = state_ff.keyLo[11:0]; // RULE_11
                        nxt_state.found = memOld.valid;
                        nxt_state.ent = memOld.valid ? memOld : '0; // RULE_16
                    end else begin
                        nxt_state.found = anyHit; // RULE_10
                        nxt_state.ent = anyHit ? hitEnt : '0; // RULE_16
                    end
                end else if (state_ff.go && state_ff.op == malt_pkg::MALT_OP_WRITE) begin
                    nxt_state.go = 1'b0;
                    nxt_state.found = 1'b0;
                    memData = state_ff.ent;
                    memData.valid = 1'b1;
                    if (!state_ff.ent.isStatic) begin
                        memWe = 1'b0; // RULE_09
                    end else if (state_ff.direct) begin
                        memWe = 1'b1;
                        memAddr = state_ff.keyLo[11:0];
                        nxt_state.found = 1'b1;
                        nxt_state.evt.almostFull = !pinned[state_ff.keyLo[1:0]] && nStat[2:1] == 2'h1;
                        if (nxt_state.evt.almostFull) begin
                            nxt_state.eidx0 = state_ff.keyLo[11:0];
                        end
                    end else if (!anyHit && bucketFull) begin
                        nxt_state.evt.writeFail = 1'b1; // RULE_05
                        nxt_state.eidx0 = {2'h0, bucket};
                    end else begin
                        memWe = 1'b1;
                        memAddr = {bucket, tgtWay};
                        memData.mac = keyMac;
                        memData.filter_group_id = keyFid;
                        nxt_state.found = 1'b1;
                        lruWe = 1'b1;
                        lruNew = malt_pkg::maltLruTouch(lruCur, tgtWay); // RULE_23
                        if (!anyHit && (nStat == 3'h2 || nStat == 3'h3)) begin
                            nxt_state.evt.almostFull = 1'b1; // RULE_04
                            nxt_state.eidx0 = {bucket, tgtWay};
                        end
                    end
                end else if (state_ff.go) begin
                    nxt_state.go = 1'b0;
                end else if (state_ff.agePend) begin
                    nxt_state.agePend = 1'b0;
                    nxt_state.scan = 13'h0000;
                    nxt_state.fsm = malt_pkg::MALT_S_AGE;
                end else if (coreReq.req && !state_ff.rsp.ack) begin
                    nxt_state.rsp.ack = 1'b1;
                    memAddr = {bucket, tgtWay};
                    memData = hitEnt;
                    memData.age = AGE_INIT; // RULE_25
                    if (!coreReq.learn) begin
                        // destination: static hit of either table wins over dynamic
                        nxt_state.rsp.hit = coreReq.stHit || anyHit; // RULE_07
                        if (coreReq.stHit && !(anyHit && hitEnt.isStatic)) begin
                            nxt_state.rsp.isStatic = 1'b1; // RULE_08
                            nxt_state.rsp.fwd = coreReq.stFwd;
                        end else if (anyHit) begin
                            nxt_state.rsp.isStatic = hitEnt.isStatic;
                            nxt_state.rsp.fwd = hitEnt.fwd;
                            nxt_state.rsp.drop = hitEnt.dstFilt;
                        end
                        memWe = anyHit && !hitEnt.isStatic;
                        lruWe = anyHit;
                    end else if (anyHit) begin
                        // source: refresh and migrate dynamic entries only
                        nxt_state.rsp.hit = 1'b1; // RULE_07
                        nxt_state.rsp.isStatic = hitEnt.isStatic;
                        nxt_state.rsp.drop = hitEnt.srcFilt;
                        memData.fwd = coreReq.port;
                        memWe = !hitEnt.isStatic;
                        lruWe = 1'b1;
                    end else if (bucketFull) begin
                        nxt_state.evt.learnFail = 1'b1; // RULE_06
                        nxt_state.eidx1 = bucket;
                    end else begin
                        memWe = 1'b1; // RULE_03
                        memData = '0;
                        memData.valid = 1'b1;
                        memData.age = AGE_INIT;
                        memData.mac = coreReq.mac;
                        memData.filter_group_id = coreReq.filter_group_id;
                        memData.fwd = coreReq.port;
                        lruWe = 1'b1;
                    end
                    lruNew = malt_pkg::maltLruTouch(lruCur, tgtWay); // RULE_23
                end
            end
            malt_pkg::MALT_S_SRCH: begin
                if (state_ff.scan[12]) begin
                    nxt_state.go = 1'b0; // RULE_19
                    nxt_state.found = 1'b0;
                    nxt_state.ent = '0; // RULE_16
                    nxt_state.fsm = malt_pkg::MALT_S_IDLE;
                end else begin
                    nxt_state.scan = state_ff.scan + 13'h0001;
                    if (memOld.valid) begin
                        nxt_state.ent = memOld; // RULE_17
                        nxt_state.found = 1'b1;
                        nxt_state.fsm = malt_pkg::MALT_S_SHOLD;
                    end
                end
            end
            malt_pkg::MALT_S_SHOLD: ;
            malt_pkg::MALT_S_AGE: begin
                if (state_ff.scan[12]) begin
                    nxt_state.fsm = malt_pkg::MALT_S_IDLE;
                end else begin
                    nxt_state.scan = state_ff.scan + 13'h0001;
                    memData = memOld;
                    memData.age = memOld.age - 3'h1;
                    memData.valid = memOld.age > 3'h1;
                    memWe = memOld.valid && !memOld.isStatic; // RULE_08 RULE_25
                end
            end
            default: nxt_state.fsm = malt_pkg::MALT_S_IDLE;
        endcase

        if (!nxt_state.go && nxt_state.fsm inside {malt_pkg::MALT_S_SRCH, malt_pkg::MALT_S_SHOLD}) begin
            nxt_state.fsm = malt_pkg::MALT_S_IDLE;
        end
        if (ageTick) begin
            nxt_state.agePend = 1'b1;
        end
        if (memWe && state_ff.fsm != malt_pkg::MALT_S_CLR) begin
            nxt_state.validCnt = state_ff.validCnt + 13'(memData.valid) - 13'(memOld.valid); // RULE_21
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge mclk) begin
        if (memWe) begin
            mem[memAddr] <= memData;
        end
        if (lruWe) begin
            lru[lruAddr] <= lruNew;
        end
    end

    assign regRdata = state_ff.rdata;
    assign coreRsp = state_ff.rsp;
    assign events = state_ff.evt;
endmodule : malt_table

// [verification/malt_table_props.sv]
// assertions and covers for the mac address lookup table ports
`timescale 1ns/1ps
module malt_table_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // core side
    input malt_pkg::malt_core_req_t coreReq,
    input wire logic ageTick,
    input malt_pkg::malt_core_rsp_t coreRsp,
    input malt_pkg::malt_events_t events
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // properties
    property p_rdZero; !regRd |=> regRdata == 32'h0; endproperty
    property p_unmapped; regRd && regAddr == 16'h0500 |=> regRdata == 32'h0; endproperty
    property p_comb; regRd && regAddr == 16'h0418 |=> regRdata[5] == (regRdata[6] || !regRdata[7]); endproperty
    property p_ackPulse; coreRsp.ack |=> !coreRsp.ack; endproperty
    property p_ackCause; coreRsp.ack |-> $past(coreReq.req); endproperty
    property p_rspQuiet; !coreRsp.ack |-> coreRsp == '0; endproperty
    property p_stWins; coreRsp.ack && $past(coreReq.stHit && !coreReq.learn) |-> coreRsp.hit; endproperty
    property p_learnFail; events.learnFail |-> $past(coreReq.req && coreReq.learn); endproperty
    property p_evtPulse; events.writeFail || events.almostFull |=> !events.writeFail && !events.almostFull; endproperty
    a_rdZero: assert property (p_rdZero) else $error("read data not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_comb: assert property (p_comb) else $error("combined bit wrong");
    a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
    a_ackCause: assert property (p_ackCause) else $error("ack without request");
    a_rspQuiet: assert property (p_rspQuiet) else $error("response without ack");
    a_stWins: assert property (p_stWins) else $error("static hit lost");
    a_learnFail: assert property (p_learnFail) else $error("learn fail without learn");
    a_evtPulse: assert property (p_evtPulse) else $error("event longer than one cycle");
    c_hit: cover property (coreRsp.ack && coreRsp.hit);
    c_full: cover property (events.almostFull);
    c_wfail: cover property (events.writeFail);
    c_lfail: cover property (events.learnFail);
endmodule : malt_table_props

// [verification/malt_host.sv]
// host model driving the register port of the lookup table
`timescale 1ns/1ps
module malt_host (
    // clock
    input wire logic mclk,
    // register port
    output logic [15:0] regAddr,
    output logic [31:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [31:0] regRdata
);
    initial {regAddr, regWdata, regWr, regRd} = '0;
    // after a strobe the address lines, and after a write the data lines, show the inverse of the last value
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        regAddr <= ~a;
        @(negedge mclk);
        d = regRdata;
    endtask : rd
endmodule : malt_host

// [verification/testbench.sv]
// self-checking bench for the mac address lookup table
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] regAddr;
    logic [31:0] regWdata, regRdata, d;
    logic regWr, regRd, ageTick;
    malt_pkg::malt_core_req_t coreReq;
    malt_pkg::malt_core_rsp_t coreRsp, r;
    malt_pkg::malt_events_t events;
    int failures = 0;
    int n_compared = 0;
    always #10 mclk = ~mclk;
    malt_host host (.*);
    malt_table uut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .coreReq(coreReq), .ageTick(ageTick), .coreRsp(coreRsp),
        .events(events));
    // ==========================================================
    // tasks
    task automatic wrap_up;
        if (failures == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic poll(input int b, input logic v);
        for (int i = 0; i < 6000; i++) begin
            host.rd(16'h0418, d);
            if (d[b] === v) return;
        end
        failures++;
        wrap_up;
    endtask : poll
    task automatic core(input logic l, input logic [47:0] m, input logic s);
        @(posedge mclk);
        coreReq <= {1'b1, l, m, 7'h00, 3'h2, s, 3'h1};
        for (int i = 0; i < 6000; i++) begin
            @(negedge mclk);
            if (coreRsp.ack === 1'b1) break;
        end
        r = coreRsp;
        @(posedge mclk);
        coreReq.req <= 1'b0;
        if (r.ack !== 1'b1) begin
            failures++;
            wrap_up;
        end
    endtask : core
    // ==========================================================
    // main sequence
    initial begin
        coreReq = '0;
        ageTick = 1'b0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        host.rd(16'h0500, d);
        chk(d, 32'h0);
        for (int w = 0; w < 4; w++) begin
            host.wr(16'h0420, 32'h8000_0000);
            host.wr(16'h042C, 32'h100 + w);
            host.wr(16'h0414, 32'h14 + w);
            host.wr(16'h0418, 32'h91);
            poll(7, 1'b0);
            chk({31'h0, d[6]}, 32'h1);
        end
        host.rd(16'h0400, d);
        chk(d, 32'h17);
        host.wr(16'h0414, 32'h5);
        host.wr(16'h0418, 32'h81);
        poll(7, 1'b0);
        chk({31'h0, d[6]}, 32'h0);
        host.rd(16'h0400, d);
        chk(d, 32'h5);
        core(1'b1, 48'h5, 1'b0);
        host.rd(16'h0404, d);
        chk(d, 32'h5);
        core(1'b1, 48'h200, 1'b0);
        chk({31'h0, r.hit}, 32'h0);
        core(1'b0, 48'h200, 1'b0);
        chk({30'h0, r.hit, r.isStatic}, 32'h2);
        core(1'b0, 48'h300, 1'b1);
        chk({31'h0, r.hit}, 32'h1);
        host.rd(16'h0418, d);
        chk({19'h0, d[28:16]}, 32'h5);
        host.wr(16'h0414, 32'h7);
        host.wr(16'h0418, 32'h82);
        poll(7, 1'b0);
        host.rd(16'h042C, d);
        chk(d, 32'h0);
        host.wr(16'h0418, 32'h83);
        for (int k = 0; k < 2; k++) begin
            poll(6, 1'b1);
            host.rd(16'h0420, d);
            chk({31'h0, d[31]}, 32'h1);
            host.rd(16'h0424, d);
            host.rd(16'h0428, d);
            host.rd(16'h042C, d);
            chk(d, 32'h100 + k);
        end
        host.wr(16'h0418, 32'h03);
        host.rd(16'h0418, d);
        chk({31'h0, d[7]}, 32'h0);
        wrap_up;
    end
endmodule : testbench
bind malt_table malt_table_props chk_i (.*);
